// [rtl/ats_top.sv]
// AHB-Lite controlled trigger source selection and input channel scanning
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "ats_defines.svh"
module ats_top #(
	parameter int PACER_W = `ATS_PACER_W
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	// Pins from the trigger connector and the input jumper
	input  wire logic                    external_trigger_input,
	input  wire logic                    single_ended_input,
	// Converter and multiplexer controls
	output ats_pkg::ats_chan_t           adc_channel,
	output ats_pkg::ats_gain_t           adc_gain,
	output logic                         adc_start,
	output logic                         adc_bipolar
);
	import ats_pkg::*;

	ats_trig_if #(.PACER_W(PACER_W)) tif (
		.clk     (clk),
		.reset_n (reset_n)
	);

	ats_pacer #(.PACER_W(PACER_W)) u_pacer (
		.p (tif.pacer)
	);

	ats_scan u_scan (
		.s (tif.scan)
	);

	// Software visible settings
	ats_chan_t              chan_setting_q;
	ats_gain_t              gain_q;
	logic                   auto_scan_enable_q;
	logic                   pacer_trigger_select_q;
	logic                   external_source_select_q;
	logic                   pretrig_q;
	logic [PACER_W-1:0]     pacer1_q;
	logic [PACER_W-1:0]     pacer2_q;

	// Bus pipeline
	logic                   wr_pend_q;
	logic [`ATS_IDX_W-1:0]  wr_idx_q;
	logic                   take;
	logic [`ATS_IDX_W-1:0]  addr_idx;
	logic [31:0]            rd_data;

	// Pin synchronisers and edge detect
	logic                   ext_s1_q;
	logic                   ext_s2_q;
	logic                   ext_s3_q;
	logic                   se_s1_q;
	logic                   se_s2_q;
	logic                   ext_fall;

	// Trigger path
	ats_src_e               src;
	logic                   sw_write;
	logic                   mode_write;
	logic                   trig_pulse;
	logic                   trig_level_q;
	logic                   trig_rise;
	ats_chan_t              last_chan;

	// Address phase accepted only on a selected NONSEQ/SEQ with bus ready
	assign take     = hsel && htrans[1] && hready;
	assign addr_idx = haddr[`ATS_IDX_W+1:2];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
		end else if (hready) begin
			wr_pend_q <= take && hwrite;
			wr_idx_q  <= addr_idx;
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data selected in the address phase, held in a register
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (addr_idx)
			`ATS_IDX_CHAN:   rd_data[4:0] = chan_setting_q;
			`ATS_IDX_GAIN:   rd_data[1:0] = gain_q;
			`ATS_IDX_MODE: begin
				rd_data[`ATS_MODE_AUTO_SCAN_ENABLE] = auto_scan_enable_q;
				rd_data[`ATS_MODE_PACER] = pacer_trigger_select_q;
				rd_data[`ATS_MODE_EXT]   = external_source_select_q;
				rd_data[`ATS_MODE_PTRG]  = pretrig_q;
			end
			`ATS_IDX_SWTRIG: begin
				rd_data[4:0]            = tif.cur_chan;
				rd_data[`ATS_STAT_SE]    = se_s2_q;
				rd_data[`ATS_STAT_START] = trig_level_q;
			end
			`ATS_IDX_PACER1: rd_data[PACER_W-1:0] = pacer1_q;
			`ATS_IDX_PACER2: rd_data[PACER_W-1:0] = pacer2_q;
			default:         rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= rd_data;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_setting_q <= `ATS_RST_CHAN;
			gain_q         <= `ATS_RST_GAIN;
		end else if (wr_pend_q) begin
			if (wr_idx_q == `ATS_IDX_CHAN) begin
				chan_setting_q <= hwdata[4:0];
			end
			if (wr_idx_q == `ATS_IDX_GAIN) begin
				gain_q <= hwdata[1:0];
			end
		end
	end

	// Each mode bit stands alone; no combination is refused
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			auto_scan_enable_q       <= 1'b0;
			pacer_trigger_select_q   <= 1'b0;
			external_source_select_q <= 1'b0;
			pretrig_q                <= 1'b0;
		end else if (mode_write) begin
			auto_scan_enable_q       <= hwdata[`ATS_MODE_AUTO_SCAN_ENABLE];
			pacer_trigger_select_q   <= hwdata[`ATS_MODE_PACER];
			external_source_select_q <= hwdata[`ATS_MODE_EXT];
			pretrig_q                <= hwdata[`ATS_MODE_PTRG];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pacer1_q <= PACER_W'(`ATS_RST_PACER);
			pacer2_q <= PACER_W'(`ATS_RST_PACER);
		end else if (wr_pend_q) begin
			if (wr_idx_q == `ATS_IDX_PACER1) begin
				pacer1_q <= hwdata[PACER_W-1:0];
			end
			if (wr_idx_q == `ATS_IDX_PACER2) begin
				pacer2_q <= hwdata[PACER_W-1:0];
			end
		end
	end

	assign mode_write = wr_pend_q && (wr_idx_q == `ATS_IDX_MODE);
	assign sw_write   = wr_pend_q && (wr_idx_q == `ATS_IDX_SWTRIG);

	// Pin inputs pass two flip-flops before use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_s1_q <= 1'b1;
			ext_s2_q <= 1'b1;
			ext_s3_q <= 1'b1;
		end else begin
			ext_s1_q <= external_trigger_input;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			se_s1_q <= 1'b1;
			se_s2_q <= 1'b1;
		end else begin
			se_s1_q <= single_ended_input;
			se_s2_q <= se_s1_q;
		end
	end

	// High-to-low on the synchronised pin
	assign ext_fall = ext_s3_q && !ext_s2_q;

	// External overrides pacer; pacer overrides software
	always_comb begin
		if (external_source_select_q) begin
			src = ATS_SRC_EXT;
		end else if (pacer_trigger_select_q) begin
			src = ATS_SRC_PACER;
		end else begin
			src = ATS_SRC_SOFT;
		end
	end

	always_comb begin
		unique case (src)
			ATS_SRC_SOFT:  trig_pulse = sw_write;
			ATS_SRC_PACER: trig_pulse = tif.pacer_tick;
			ATS_SRC_EXT:   trig_pulse = ext_fall;
			default:       trig_pulse = 1'b0;
		endcase
	end

	// Conversion begins on the rising edge of the internal trigger
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_level_q <= 1'b0;
		end else begin
			trig_level_q <= trig_pulse;
		end
	end

	assign trig_rise = trig_pulse && !trig_level_q;

	// Differential wiring leaves only 16 valid channel numbers
	assign last_chan = se_s2_q ? chan_setting_q
		: (chan_setting_q & `ATS_DIFF_MASK);

	assign tif.trig      = trig_rise;
	assign tif.restart   = mode_write && hwdata[`ATS_MODE_AUTO_SCAN_ENABLE]
		&& !auto_scan_enable_q;
	assign tif.auto_scan = auto_scan_enable_q;
	assign tif.last_chan = last_chan;
	assign tif.pacer_en  = pacer_trigger_select_q
		&& !external_source_select_q;
	assign tif.div1      = pacer1_q;
	assign tif.div2      = pacer2_q;

	// Converter controls, all registered
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			adc_channel <= `ATS_RST_CHAN;
			adc_gain    <= `ATS_RST_GAIN;
			adc_start   <= 1'b0;
			adc_bipolar <= 1'b1;
		end else begin
			adc_channel <= tif.sel_chan;
			adc_gain    <= gain_q;
			adc_start   <= trig_rise;
			adc_bipolar <= 1'b1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence ext_edge_s;
		(ext_s2_q && external_source_select_q)
		##1 (!ext_s2_q && external_source_select_q && !trig_level_q);
	endsequence

	ext_trig_start_a: assert property (ext_edge_s |=> adc_start)
		else $error("external falling edge gave no conversion start");
	sw_trig_start_a: assert property (sw_write && src == ATS_SRC_SOFT
		&& !trig_level_q |=> adc_start ##1 !adc_start)
		else $error("software trigger did not give one start");
	ext_ignores_sw_a: assert property (sw_write && external_source_select_q
		&& !ext_fall |=> !adc_start)
		else $error("software write triggered in external mode");
	pacer_start_a: assert property (tif.pacer_tick && src == ATS_SRC_PACER
		&& !trig_level_q |=> adc_start)
		else $error("pacer tick gave no conversion start");
	start_pulse_a: assert property (adc_start |=> !adc_start)
		else $error("conversion start longer than one cycle");
	fixed_chan_a: assert property (!auto_scan_enable_q
		|=> adc_channel == $past(last_chan))
		else $error("fixed channel not routed");
	chan_read_a: assert property (take && !hwrite
		&& addr_idx == `ATS_IDX_CHAN |=> hrdata[4:0] == $past(chan_setting_q))
		else $error("channel readback differs from setting");
	diff_range_a: assert property (!se_s2_q |-> !last_chan[4])
		else $error("differential channel out of range");
	gain_scan_a: assert property (adc_start
		|-> adc_gain == $past(gain_q))
		else $error("gain changed with channel");
	bipolar_a: assert property (adc_bipolar)
		else $error("bipolar mode dropped");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus response not OKAY and ready");

	sequence chan_wr_s;
		wr_pend_q && (wr_idx_q == `ATS_IDX_CHAN);
	endsequence

	sequence gain_wr_s;
		wr_pend_q && (wr_idx_q == `ATS_IDX_GAIN);
	endsequence

	sequence scan_on_s;
		mode_write && hwdata[`ATS_MODE_AUTO_SCAN_ENABLE] && !auto_scan_enable_q;
	endsequence

	chan_write_a: assert property (chan_wr_s
		|=> chan_setting_q == $past(hwdata[4:0]))
		else $error("channel setting not written");
	gain_write_a: assert property (gain_wr_s
		|=> gain_q == $past(hwdata[1:0]))
		else $error("gain setting not written");
	scan_start_a: assert property (scan_on_s
		|=> auto_scan_enable_q && tif.cur_chan == 5'h00)
		else $error("scan did not start at channel 0");
	scan_route_a: assert property (auto_scan_enable_q
		|=> adc_channel == $past(tif.cur_chan))
		else $error("scan position not routed");
	se_status_a: assert property (take && !hwrite
		&& addr_idx == `ATS_IDX_SWTRIG
		|=> hrdata[`ATS_STAT_SE] == $past(se_s2_q))
		else $error("input wiring status not reported");
	ext_mutes_pacer_a: assert property (external_source_select_q
		|=> !tif.pacer_tick)
		else $error("pacer ticked in external mode");
	pacer_mutes_sw_a: assert property (sw_write
		&& src == ATS_SRC_PACER && !tif.pacer_tick |=> !adc_start)
		else $error("software write triggered in pacer mode");
endmodule

// [rtl/ats_defines.svh]
// Register indices, field positions, reset values and widths
`ifndef ATS_DEFINES_SVH
`define ATS_DEFINES_SVH
`define ATS_IDX_W          8
`define ATS_IDX_CHAN       8'h02
`define ATS_IDX_GAIN       8'h04
`define ATS_IDX_MODE       8'h06
`define ATS_IDX_SWTRIG     8'h0A
`define ATS_IDX_PACER1     8'h22
`define ATS_IDX_PACER2     8'h24
`define ATS_CHAN_W         5
`define ATS_GAIN_W         2
`define ATS_PACER_W        16
`define ATS_MODE_AUTO_SCAN_ENABLE     0
`define ATS_MODE_PACER     1
`define ATS_MODE_EXT       2
`define ATS_MODE_PTRG      3
`define ATS_STAT_SE        5
`define ATS_STAT_START     6
`define ATS_RST_CHAN       5'h00
`define ATS_RST_GAIN       2'h0
`define ATS_RST_PACER      16'h0064
`define ATS_DIFF_MASK      5'h0F
`endif

// [rtl/ats_pkg.sv]
// Types shared by the trigger and scan control
package ats_pkg;
	typedef logic [4:0] ats_chan_t;
	typedef logic [1:0] ats_gain_t;
	typedef enum logic [1:0] {
		ATS_SRC_SOFT,
		ATS_SRC_PACER,
		ATS_SRC_EXT
	} ats_src_e;
endpackage

// [rtl/ats_trig_if.sv]
// Signals between the control top, the pacer and the channel scanner
`timescale 1ns/100ps
interface ats_trig_if #(parameter int PACER_W = 16) (
	input wire logic clk,
	input wire logic reset_n
);
	import ats_pkg::*;
	logic               trig;
	logic               restart;
	logic               auto_scan;
	ats_chan_t          last_chan;
	ats_chan_t          sel_chan;
	ats_chan_t          cur_chan;
	logic               pacer_en;
	logic [PACER_W-1:0] div1;
	logic [PACER_W-1:0] div2;
	logic               pacer_tick;
	modport top (output trig, restart, auto_scan, last_chan, pacer_en,
		div1, div2, input sel_chan, cur_chan, pacer_tick);
	modport scan (input clk, reset_n, trig, restart, auto_scan,
		last_chan, output sel_chan, cur_chan);
	modport pacer (input clk, reset_n, pacer_en, div1, div2,
		output pacer_tick);
endinterface

// [rtl/ats_pacer.sv]
// Two cascaded down counters giving a periodic trigger tick
`timescale 1ns/100ps
module ats_pacer #(parameter int PACER_W = 16) (
	ats_trig_if.pacer p
);
	import ats_pkg::*;
	logic [PACER_W-1:0] cnt1_q;
	logic [PACER_W-1:0] cnt2_q;
	logic               stage1_end;

	// First counter expires every div1 clocks (0 acts as 1)
	assign stage1_end = p.pacer_en && (cnt1_q <= PACER_W'(1));

	always_ff @(posedge p.clk or negedge p.reset_n) begin
		if (!p.reset_n) begin
			cnt1_q <= '0;
			cnt2_q <= '0;
			p.pacer_tick <= 1'b0;
		end else if (!p.pacer_en) begin
			cnt1_q <= p.div1;
			cnt2_q <= p.div2;
			p.pacer_tick <= 1'b0;
		end else begin
			cnt1_q <= stage1_end ? p.div1 : cnt1_q - PACER_W'(1);
			p.pacer_tick <= 1'b0;
			if (stage1_end) begin
				if (cnt2_q <= PACER_W'(1)) begin
					cnt2_q <= p.div2;
					p.pacer_tick <= 1'b1;
				end else begin
					cnt2_q <= cnt2_q - PACER_W'(1);
				end
			end
		end
	end

	default clocking @(posedge p.clk); endclocking
	default disable iff (!p.reset_n);
	pacer_idle_a: assert property (!p.pacer_en |=> !p.pacer_tick)
		else $error("pacer ticked while disabled");
endmodule

// [rtl/ats_scan.sv]
// Channel selection: fixed channel or automatic scan from channel 0
`timescale 1ns/100ps
module ats_scan (
	ats_trig_if.scan s
);
	import ats_pkg::*;
	ats_chan_t next_chan;

	// Wrap after the last channel, or if the end was lowered below us
	assign next_chan = (s.cur_chan >= s.last_chan) ? '0
		: s.cur_chan + 5'h01;

	always_ff @(posedge s.clk or negedge s.reset_n) begin
		if (!s.reset_n) begin
			s.cur_chan <= '0;
		end else if (s.restart) begin
			s.cur_chan <= '0;
		end else if (s.trig && s.auto_scan) begin
			s.cur_chan <= next_chan;
		end
	end

	// Fixed channel (the end channel), or the scan position passed on unclamped even if above the end channel
	assign s.sel_chan = s.auto_scan ? s.cur_chan : s.last_chan;

	default clocking @(posedge s.clk); endclocking
	default disable iff (!s.reset_n);
	scan_wrap_a: assert property (s.trig && s.auto_scan && !s.restart
		&& s.cur_chan == s.last_chan |=> s.cur_chan == 5'h00)
		else $error("scan did not wrap to channel 0");
	scan_step_a: assert property (s.trig && s.auto_scan && !s.restart
		&& s.cur_chan < s.last_chan |=> s.cur_chan == $past(s.cur_chan) + 5'h01)
		else $error("scan did not advance by one");
	scan_restart_a: assert property (s.restart |=> s.cur_chan == 5'h00)
		else $error("scan restart did not return to channel 0");
	scan_hold_a: assert property (!s.trig && !s.restart |=> $stable(s.cur_chan))
		else $error("scan moved without a trigger");
endmodule

// [tb/ats_far_model.sv]
// Far-side model: converter, input multiplexer and trigger source
`timescale 1ns/100ps
module ats_far_model (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// Converter controls from the block
	input  wire logic               adc_start,
	input  wire ats_pkg::ats_chan_t adc_channel,
	input  wire ats_pkg::ats_gain_t adc_gain,
	// Request for one falling edge on the pin
	input  wire logic               fire,
	// Trigger pin and what the converter saw
	output logic                    external_trigger_input,
	output int                      start_count,
	output ats_pkg::ats_chan_t      conv_chan,
	output ats_pkg::ats_gain_t      conv_gain
);
	import ats_pkg::*;
	logic [2:0] low_cnt_q;

	// Pin idles high, held low four cycles per request
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt_q <= 3'h0;
		end else if (fire) begin
			low_cnt_q <= 3'h4;
		end else if (low_cnt_q != 3'h0) begin
			low_cnt_q <= low_cnt_q - 3'h1;
		end
	end
	assign external_trigger_input = (low_cnt_q == 3'h0);

	// Mux and gain latched at each conversion start
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_count <= 0;
			conv_chan   <= 5'h00;
			conv_gain   <= 2'h0;
		end else if (adc_start) begin
			start_count <= start_count + 1;
			conv_chan   <= adc_channel;
			conv_gain   <= adc_gain;
		end
	end
endmodule

// [tb/ats_top_tb.sv]
// Self-checking bench for the trigger and scan control
`timescale 1ns/100ps
`include "ats_defines.svh"
module ats_top_tb;
	import ats_pkg::*;
	logic        clk, reset_n, hsel, hwrite, fire, single_ended_input;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, ext_pin, adc_start, adc_bipolar;
	ats_chan_t   adc_channel, conv_chan;
	ats_gain_t   adc_gain, conv_gain;
	int          start_count, miscompares, samples_checked, cyc;

	ats_top #(.PACER_W(16)) dut_u (
		.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.external_trigger_input(ext_pin),
		.single_ended_input(single_ended_input),
		.adc_channel(adc_channel), .adc_gain(adc_gain),
		.adc_start(adc_start), .adc_bipolar(adc_bipolar)
	);

	ats_far_model far_u (
		.clk(clk), .reset_n(reset_n), .adc_start(adc_start),
		.adc_channel(adc_channel), .adc_gain(adc_gain), .fire(fire),
		.external_trigger_input(ext_pin), .start_count(start_count),
		.conv_chan(conv_chan), .conv_gain(conv_gain)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One single AHB transfer, waits on hready in both phases
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, idx, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, idx, 32'h0, r);
		check(r, exp);
		check({31'h0, hresp}, 32'h0);
	endtask

	// Software trigger expecting one start on the given channel
	task automatic fire_soft(input ats_chan_t ch, input ats_gain_t g);
		int c0;
		c0 = start_count;
		wr(`ATS_IDX_SWTRIG, 32'h0000_00A5);
		repeat (4) @(negedge clk);
		check(32'(start_count - c0), 32'h1);
		check({27'h0, conv_chan}, {27'h0, ch});
		check({30'h0, conv_gain}, {30'h0, g});
	endtask

	task automatic wait_start(output int t);
		int c0;
		int n;
		c0 = start_count;
		n = 0;
		while (start_count == c0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check(32'(start_count != c0), 32'h1);
		t = cyc;
	endtask

	task automatic t_reset();
		rd_chk(`ATS_IDX_CHAN, 32'h0);
		rd_chk(`ATS_IDX_PACER1, 32'h0064);
		check({31'h0, adc_bipolar}, 32'h1);
		check({27'h0, adc_channel}, 32'h0);
	endtask

	task automatic t_fixed();
		wr(`ATS_IDX_CHAN, 32'hFFFF_FFE6);
		rd_chk(`ATS_IDX_CHAN, 32'h6);
		fire_soft(5'h06, 2'h0);
		fire_soft(5'h06, 2'h0);
	endtask

	task automatic t_scan();
		wr(`ATS_IDX_GAIN, 32'h2);
		wr(`ATS_IDX_CHAN, 32'h3);
		wr(`ATS_IDX_MODE, 32'h1);
		for (int i = 0; i < 6; i++) begin
			fire_soft(5'(i % 4), 2'h2);
		end
		rd_chk(`ATS_IDX_CHAN, 32'h3);
		wr(`ATS_IDX_MODE, 32'h0);
		wr(`ATS_IDX_MODE, 32'h1);
		fire_soft(5'h00, 2'h2);
		wr(`ATS_IDX_MODE, 32'h0);
		fire_soft(5'h03, 2'h2);
	endtask

	task automatic t_gain();
		for (int g = 0; g < 4; g++) begin
			wr(`ATS_IDX_GAIN, 32'(g));
			rd_chk(`ATS_IDX_GAIN, 32'(g));
			@(negedge clk);
			check({30'h0, adc_gain}, 32'(g));
		end
	endtask

	task automatic t_pacer();
		int t1;
		int t2;
		wr(`ATS_IDX_PACER1, 32'h2);
		wr(`ATS_IDX_PACER2, 32'h3);
		wr(`ATS_IDX_MODE, 32'h2);
		wait_start(t1);
		wait_start(t2);
		check(32'(t2 - t1), 32'h6);
	endtask

	task automatic t_ext();
		int c0;
		int t;
		wr(`ATS_IDX_MODE, 32'h6);
		repeat (4) @(negedge clk);
		c0 = start_count;
		repeat (40) @(negedge clk);
		wr(`ATS_IDX_SWTRIG, 32'h1);
		repeat (4) @(negedge clk);
		check(32'(start_count - c0), 32'h0);
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		wait_start(t);
		repeat (12) @(negedge clk);
		check(32'(start_count - c0), 32'h1);
	endtask

	task automatic t_diff();
		@(posedge clk);
		single_ended_input <= 1'b0;
		wr(`ATS_IDX_MODE, 32'h8);
		wr(`ATS_IDX_CHAN, 32'h1F);
		repeat (4) @(posedge clk);
		rd_chk(`ATS_IDX_SWTRIG, 32'h0000_0001);
		fire_soft(5'h0F, 2'h3);
		fire_soft(5'h0F, 2'h3);
	endtask

	initial begin
		miscompares = 0;
		samples_checked = 0;
		cyc = 0;
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		fire = 1'b0;
		single_ended_input = 1'b1;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_fixed();
		t_scan();
		t_gain();
		t_pacer();
		t_ext();
		t_diff();
		conclude();
	end

	// Hang guard well beyond the whole sequence
	initial begin
		#(25 * 20000);
		miscompares++;
		conclude();
	end
endmodule
